/* core/tlih_pkg.sv */
// package for the two-level interrupt handler: map, layouts, timing
// assumes an AXI4-Lite master and a CPU pipeline on the same clock
package tlih_pkg;

    localparam int unsigned NUM_ORDERS = 15;
    localparam int unsigned CLK_MHZ    = 25;
    localparam int unsigned DETECT_NS  = 40;
    localparam int unsigned DETECT_CYC =
        (DETECT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CALL_CYC   = 4;

    // order numbers
    localparam int unsigned ORD_EXT0 = 0;
    localparam int unsigned ORD_TMR0 = 1;
    localparam int unsigned ORD_EXT1 = 2;
    localparam int unsigned ORD_TMR1 = 3;
    localparam int unsigned ORD_RSV0 = 8;
    localparam int unsigned ORD_RSV1 = 13;

    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_BASE  = 16'h0003;
    localparam logic [15:0] VEC_STEP  = 16'h0008;

    // valid orders: all but the two reserved slots
    localparam logic [14:0] ORDER_VALID = 15'h5EFF;
    // flags cleared by hardware on vectoring
    localparam logic [14:0] HW_CLEAR    = 15'h000F;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ENABLE  = 8'h04;
    localparam logic [7:0] OFS_PRIO    = 8'h08;
    localparam logic [7:0] OFS_PEND    = 8'h0C;
    localparam logic [7:0] OFS_PSET    = 8'h10;
    localparam logic [7:0] OFS_PCLR    = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;

    // control register fields
    localparam int unsigned CTRL_GEN  = 0;
    localparam int unsigned CTRL_IT0  = 1;
    localparam int unsigned CTRL_IT1  = 2;
    localparam int unsigned CTRL_PL0  = 3;
    localparam int unsigned CTRL_PL1  = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // cpu pipeline status toward the handler
    typedef struct packed {
        logic instr_done;   // current instruction completes this cycle
        logic is_return_from_interrupt;      // completing instruction is a return
        logic clears_gen;   // completing instruction clears global enable
        logic next_multi;   // following instruction is multi-cycle
    } tlih_cpu_t;

    // vector request toward the cpu
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [3:0]  order;
        logic        high;
    } tlih_call_t;

endpackage : tlih_pkg

/* core/tlih_top.sv */
// two-level interrupt handler with AXI4-Lite registers
// assumes cpu status, flag set pulses and pins; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module tlih_top
#(
    parameter int unsigned N_SRC = 15
)
(
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // axi4-lite write
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    output var  logic [1:0]          s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    output var  logic [31:0]         s_axi_rdata,
    output var  logic [1:0]          s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // peripherals and pins
    input  wire logic [N_SRC-1:0]    periph_set,
    input  wire logic                external_irq_zero,
    input  wire logic                external_irq_one,
    // cpu pipeline
    input  wire tlih_pkg::tlih_cpu_t cpu,
    output var  tlih_pkg::tlih_call_t call_q,
    output var  logic                global_irq_enable_q
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CALL = 2'b10,
        ST_HOLD = 2'b11
    } tlih_state_t;

    tlih_state_t             state_q;
    logic [N_SRC-1:0]        pend_q;
    logic [N_SRC-1:0]        enable_q;
    logic [N_SRC-1:0]        prio_q;
    logic                    ext0_trigger_type_q;
    logic                    ext1_trigger_type_q;
    logic                    ext0_polarity_q;
    logic                    ext1_polarity_q;
    logic                    in_svc_lo_q;
    logic                    in_svc_hi_q;
    logic                    return_from_interrupt_gap_q;
    logic [1:0]              call_cnt_q;
    logic [1:0]              sync0_q;
    logic [1:0]              sync1_q;
    logic [1:0]              prev_q;
    logic                    aw_held_q;
    logic                    w_held_q;
    logic [7:0]              awaddr_q;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;

    // ----------------------------------------------------------------
    // external inputs
    // ----------------------------------------------------------------
    logic act0;
    logic act1;

    // pins are only observed, never driven, so other users are unaffected
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // pins start idle for the default low polarity: no false edge
            sync0_q <= 2'h3;
            sync1_q <= 2'h3;
            prev_q  <= 2'h0;
        end
        else
        begin
            sync0_q <= {sync0_q[0], external_irq_zero};
            sync1_q <= {sync1_q[0], external_irq_one};
            prev_q  <= {act1, act0};
        end
    end

    assign act0 = ~(sync0_q[1] ^ ext0_polarity_q);
    assign act1 = ~(sync1_q[1] ^ ext1_polarity_q);

    logic [N_SRC-1:0] ext_edge;
    logic [N_SRC-1:0] ext_level_mask;
    logic [N_SRC-1:0] ext_level_val;
    always_comb
    begin
        ext_edge       = '0;
        ext_level_mask = '0;
        ext_level_val  = '0;
        ext_edge[tlih_pkg::ORD_EXT0] = ext0_trigger_type_q
                                       & act0 & ~prev_q[0];
        ext_edge[tlih_pkg::ORD_EXT1] = ext1_trigger_type_q
                                       & act1 & ~prev_q[1];
        ext_level_mask[tlih_pkg::ORD_EXT0] = ~ext0_trigger_type_q;
        ext_level_mask[tlih_pkg::ORD_EXT1] = ~ext1_trigger_type_q;
        ext_level_val[tlih_pkg::ORD_EXT0]  = act0;
        ext_level_val[tlih_pkg::ORD_EXT1]  = act1;
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    logic [N_SRC-1:0] req;
    logic [N_SRC-1:0] req_hi;
    logic [N_SRC-1:0] pick_vec;
    logic [3:0]       pick;
    logic             pick_hi;
    logic             any_req;
    logic             allowed;

    // flags stay set even while disabled; vectoring just ignores them
    assign req = pend_q & enable_q & tlih_pkg::ORDER_VALID[N_SRC-1:0]
                 & {N_SRC{global_irq_enable_q}};
    assign req_hi  = req & prio_q;
    assign any_req = |req;
    assign pick_hi = |req_hi;
    assign pick_vec = pick_hi ? req_hi : req;

    always_comb
    begin
        pick = '0;
        // lowest order number wins within a level
        for (int i = N_SRC - 1; i >= 0; i--)
        begin
            if (pick_vec[i])
            begin
                pick = 4'(i);
            end
        end
    end

    // high may preempt low; nothing preempts high
    assign allowed = any_req && !in_svc_hi_q
                     && (!in_svc_lo_q || pick_hi)
                     && !return_from_interrupt_gap_q;

    // an enable-clear followed by multi-cycle work blocks the call
    logic take;
    assign take = allowed && cpu.instr_done && !cpu.is_return_from_interrupt
                  && !(cpu.clears_gen && cpu.next_multi);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q    <= ST_IDLE;
            call_cnt_q <= 2'h0;
            call_q     <= '0;
            call_q.addr <= tlih_pkg::VEC_RESET;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    call_q.valid <= 1'b0;
                    if (allowed)
                    begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    // request sampled; wait for instruction boundary
                    if (!allowed)
                    begin
                        state_q <= ST_IDLE;
                    end
                    else if (take)
                    begin
                        state_q      <= ST_CALL;
                        call_cnt_q   <= 2'(tlih_pkg::CALL_CYC - 1);
                        call_q.valid <= 1'b1;
                        call_q.order <= pick;
                        call_q.high  <= pick_hi;
                        call_q.addr  <= tlih_pkg::VEC_BASE
                            + 16'(pick) * tlih_pkg::VEC_STEP;
                    end
                end
                ST_CALL:
                begin
                    // long call runs for the call duration
                    if (call_cnt_q == 2'h1)
                    begin
                        state_q <= ST_HOLD;
                    end
                    call_cnt_q <= call_cnt_q - 2'h1;
                end
                ST_HOLD:
                begin
                    call_q.valid <= 1'b0;
                    state_q      <= ST_IDLE;
                end
            endcase
        end
    end

    logic vectoring;
    assign vectoring = (state_q == ST_WAIT) && take;

    // ----------------------------------------------------------------
    // in-service levels
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_svc_lo_q <= 1'b0;
            in_svc_hi_q <= 1'b0;
            return_from_interrupt_gap_q  <= 1'b0;
        end
        else
        begin
            if (cpu.instr_done)
            begin
                return_from_interrupt_gap_q <= cpu.is_return_from_interrupt;
            end
            if (vectoring)
            begin
                if (pick_hi)
                begin
                    in_svc_hi_q <= 1'b1;
                end
                else
                begin
                    in_svc_lo_q <= 1'b1;
                end
            end
            else if (cpu.instr_done && cpu.is_return_from_interrupt)
            begin
                // return ends the innermost level; low resumes
                if (in_svc_hi_q)
                begin
                    in_svc_hi_q <= 1'b0;
                end
                else
                begin
                    in_svc_lo_q <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic wr_fire;
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tlih_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_q && !s_axi_awready;
            s_axi_wready  <= !w_held_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_ok(awaddr_q) ? tlih_pkg::RESP_OKAY
                                                  : tlih_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
            end
        end
    end

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == tlih_pkg::OFS_CTRL) || (a == tlih_pkg::OFS_ENABLE)
               || (a == tlih_pkg::OFS_PRIO) || (a == tlih_pkg::OFS_PEND)
               || (a == tlih_pkg::OFS_PSET) || (a == tlih_pkg::OFS_PCLR)
               || (a == tlih_pkg::OFS_STATUS);
    endfunction

    // write data with byte enables applied to the low two lanes
    logic [15:0] wmask;
    assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    logic [N_SRC-1:0] wbits;
    assign wbits = wdata_q[N_SRC-1:0] & wmask[N_SRC-1:0];

    logic wr_ctrl;
    logic wr_pset;
    logic wr_pclr;
    assign wr_ctrl = wr_fire && awaddr_q == tlih_pkg::OFS_CTRL && wstrb_q[0];
    assign wr_pset = wr_fire && awaddr_q == tlih_pkg::OFS_PSET;
    assign wr_pclr = wr_fire && awaddr_q == tlih_pkg::OFS_PCLR;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            global_irq_enable_q <= 1'b0;
            ext0_trigger_type_q <= 1'b0;
            ext1_trigger_type_q <= 1'b0;
            ext0_polarity_q     <= 1'b0;
            ext1_polarity_q     <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                global_irq_enable_q <= wdata_q[tlih_pkg::CTRL_GEN];
                ext0_trigger_type_q <= wdata_q[tlih_pkg::CTRL_IT0];
                ext1_trigger_type_q <= wdata_q[tlih_pkg::CTRL_IT1];
                ext0_polarity_q     <= wdata_q[tlih_pkg::CTRL_PL0];
                ext1_polarity_q     <= wdata_q[tlih_pkg::CTRL_PL1];
            end
            if (cpu.instr_done && cpu.clears_gen)
            begin
                // cleared before any slipped-through routine can read it
                global_irq_enable_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_q <= '0;
            prio_q   <= '0;
        end
        else if (wr_fire && awaddr_q == tlih_pkg::OFS_ENABLE)
        begin
            enable_q <= (enable_q & ~wmask[N_SRC-1:0]) | wbits;
        end
        else if (wr_fire && awaddr_q == tlih_pkg::OFS_PRIO)
        begin
            prio_q <= (prio_q & ~wmask[N_SRC-1:0]) | wbits;
        end
    end

    // pending flags: a level-mode pin decides its flag; otherwise set wins over every clear
    logic [N_SRC-1:0] hw_clr;
    assign hw_clr = vectoring ? (tlih_pkg::HW_CLEAR[N_SRC-1:0]
                    & (N_SRC'(1) << pick)) : '0;

    generate
        for (genvar g = 0; g < N_SRC; g++)
        begin : g_flag
            logic hw_clr_bit;
            assign hw_clr_bit = hw_clr[g]
                && !(g == tlih_pkg::ORD_EXT0 && !ext0_trigger_type_q)
                && !(g == tlih_pkg::ORD_EXT1 && !ext1_trigger_type_q);
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    pend_q[g] <= 1'b0;
                end
                else if (ext_level_mask[g])
                begin
                    pend_q[g] <= ext_level_val[g];
                end
                else if (periph_set[g] || ext_edge[g]
                         || (wr_pset && wbits[g]))
                begin
                    pend_q[g] <= 1'b1;
                end
                else if (hw_clr_bit || (wr_pclr && wbits[g]))
                begin
                    pend_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= tlih_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= tlih_pkg::RESP_OKAY;
                s_axi_rdata   <= '0;
                unique case (s_axi_araddr)
                    tlih_pkg::OFS_CTRL:
                        s_axi_rdata[4:0] <= {ext1_polarity_q, ext0_polarity_q,
                            ext1_trigger_type_q, ext0_trigger_type_q,
                            global_irq_enable_q};
                    tlih_pkg::OFS_ENABLE:
                        s_axi_rdata[N_SRC-1:0] <= enable_q;
                    tlih_pkg::OFS_PRIO:
                        s_axi_rdata[N_SRC-1:0] <= prio_q;
                    tlih_pkg::OFS_PEND:
                        s_axi_rdata[N_SRC-1:0] <= pend_q;
                    tlih_pkg::OFS_PSET, tlih_pkg::OFS_PCLR:
                        s_axi_rdata <= '0;
                    tlih_pkg::OFS_STATUS:
                        s_axi_rdata[3:0] <= {return_from_interrupt_gap_q, in_svc_hi_q,
                                             in_svc_lo_q, call_q.valid};
                    default:
                        s_axi_rresp <= tlih_pkg::RESP_SLVERR;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // tlih_top
`default_nettype wire

/* tb/tlih_cpu_model.sv */
// cpu pipeline model facing the interrupt handler
// assumes one instruction ends each clock unless a call runs
`timescale 1ns/1ps
`default_nettype none
module tlih_cpu_model (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // handler call and bench commands
    input  wire tlih_pkg::tlih_call_t call_q,
    input  wire logic                 return_from_interrupt,
    input  wire logic                 clr,
    // status toward the handler
    output var  tlih_pkg::tlih_cpu_t  cpu
);
    logic done;
    // the long call stalls the pipeline
    assign done = aresetn && !call_q.valid;
    // clearing instruction padded by a two-byte one
    assign cpu = '{done, done && return_from_interrupt, done && clr, clr};
endmodule // tlih_cpu_model
`default_nettype wire

/* tb/tlih_top_asserts.sv */
// checker for the two-level interrupt handler
// assumes bind onto tlih_top; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module tlih_top_asserts (
    // clock and reset
    input wire logic                 aclk,
    input wire logic                 aresetn,
    // bus answers
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    // cpu side
    input wire tlih_pkg::tlih_cpu_t  cpu,
    input wire tlih_pkg::tlih_call_t call_q,
    input wire logic                 global_irq_enable_q
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_CALL_LEN: assert property ($rose(call_q.valid) |->
        call_q.valid[*4] ##1 !call_q.valid) else $error("call length");
    AST_CALL_DONE: assert property ($rose(call_q.valid) |->
        $past(cpu.instr_done)) else $error("call before instr end");
    AST_VEC: assert property (call_q.valid |-> call_q.addr ==
        16'h0003 + {9'h0, call_q.order, 3'h0}) else $error("vector");
    AST_NO_RSV: assert property (call_q.valid |->
        !(call_q.order inside {4'h8, 4'hD, 4'hF})) else $error("order");
    AST_GEN_OFF: assert property ((!global_irq_enable_q)[*3]
        |=> !$rose(call_q.valid)) else $error("call while disabled");
    AST_CLR_MULTI: assert property (cpu.instr_done &&
        cpu.clears_gen && cpu.next_multi |=> !$rose(call_q.valid))
        else $error("call after enable clear");
    AST_RET_GAP: assert property ($rose(call_q.valid) |->
        !$past(cpu.is_return_from_interrupt)) else $error("call right after return");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid) else $error("rvalid dropped");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped");
    cover property ($rose(call_q.valid) && call_q.high);
    cover property ($rose(call_q.valid) && !call_q.high);
    cover property (cpu.is_return_from_interrupt);
endmodule // tlih_top_asserts
bind tlih_top tlih_top_asserts u_tlih_top_asserts (.aclk(aclk),
    .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .cpu(cpu), .call_q(call_q),
    .global_irq_enable_q(global_irq_enable_q));
`default_nettype wire

/* tb/tlih_top_bench.sv */
// bench for the two-level interrupt handler
// assumes the cpu model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tlih_top_bench;
    logic aclk = 1'b0, aresetn = 1'b0, ext0 = 1'b1, ext1 = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, return_from_interrupt = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, clr = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [14:0] pset = 15'h0;
    logic awready, wready, bvalid, arready, rvalid, gen;
    logic [1:0] bresp, rresp;
    tlih_pkg::tlih_cpu_t cpu;
    tlih_pkg::tlih_call_t call_q;
    int err_total = 0, check_count = 0, cyc = 0;
    always #20 aclk = ~aclk;
    tlih_top u_tlih_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .periph_set(pset),
        .external_irq_zero(ext0), .external_irq_one(ext1),
        .cpu(cpu), .call_q(call_q), .global_irq_enable_q(gen));
    tlih_cpu_model u_tlih_cpu_model (.aclk(aclk), .aresetn(aresetn),
        .call_q(call_q), .return_from_interrupt(return_from_interrupt), .clr(clr), .cpu(cpu));
    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", what, e, g);
        end
    endtask
    function automatic logic [31:0] exp_resp(logic [7:0] a);
        return {30'h0, (a > 8'h18) ? 2'h2 : 2'h0};
    endfunction
    task automatic wr(logic [7:0] a, logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                bready <= 1'b0;
                chk("bresp", exp_resp(a), {30'h0, bresp});
            end
        end
        while (awvalid || wvalid || bready);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                rready <= 1'b0;
                chk("rresp", exp_resp(a), {30'h0, rresp});
                if (a <= 8'h18) chk("rdata", e, rdata & m);
            end
        end
        while (arvalid || rready);
    endtask
    task automatic wait_call(logic [15:0] v);
        int n;
        n = 0;
        while (call_q.valid !== 1'b1 && n < 40)
        begin
            @(posedge aclk);
            n++;
        end
        chk("call", 32'h1, {31'h0, call_q.valid});
        chk("vector", {16'h0, v}, {16'h0, call_q.addr});
        repeat (5) @(posedge aclk);
    endtask
    task automatic do_return_from_interrupt();
        @(posedge aclk) return_from_interrupt <= 1'b1;
        @(posedge aclk) return_from_interrupt <= 1'b0;
    endtask
    task automatic t_reset();
        chk("gen", 32'h0, {31'h0, gen});
        rd(8'h00, 32'h0, 32'h1F);
        rd(8'h08, 32'h0, 32'h7FFF);
        wr(8'h1C, 32'h1);
        rd(8'h1C, 32'h0, 32'h0);
    endtask
    task automatic t_orders();
        wr(8'h00, 32'h7);
        wr(8'h04, 32'h7FFF);
        for (int o = 0; o < 15; o++)
            if (o != 8 && o != 13)
            begin
                wr(8'h10, 32'h1 << o);
                wait_call(16'h0003 + 16'(8 * o));
                rd(8'h0C, (o < 4) ? 32'h0 : 32'h1 << o, 32'h1 << o);
                wr(8'h14, 32'h1 << o);
                do_return_from_interrupt();
            end
    endtask
    task automatic t_prio();
        wr(8'h08, 32'h200);
        wr(8'h10, 32'h250);
        wait_call(16'h004B);
        chk("high", 32'h1, {31'h0, call_q.high});
        rd(8'h18, 32'h4, 32'h6);
        wr(8'h14, 32'h200);
        repeat (10) @(posedge aclk);
        chk("held", 32'h0, {31'h0, call_q.valid});
        do_return_from_interrupt();
        wait_call(16'h0023);
        chk("high", 32'h0, {31'h0, call_q.high});
        wr(8'h14, 32'h10);
        do_return_from_interrupt();
        wait_call(16'h0033);
        wr(8'h14, 32'h40);
        do_return_from_interrupt();
    endtask
    task automatic t_ext();
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h13);
        ext1 <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(8'h0C, 32'h4, 32'h4);
        ext1 <= 1'b0;
        ext0 <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(8'h0C, 32'h1, 32'h5);
        ext0 <= 1'b1;
        wr(8'h04, 32'h1);
        wait_call(16'h0003);
        rd(8'h0C, 32'h0, 32'h1);
        do_return_from_interrupt();
    endtask
    task automatic t_gen();
        wr(8'h04, 32'h400);
        pset <= 15'h400;
        @(posedge aclk) pset <= 15'h0;
        @(posedge aclk) clr <= 1'b1;
        @(posedge aclk) clr <= 1'b0;
        repeat (10) @(posedge aclk);
        chk("no call", 32'h0, {31'h0, call_q.valid});
        rd(8'h00, 32'h0, 32'h1);
        wr(8'h14, 32'h400);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_sim();
        end
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_orders();
        t_prio();
        t_ext();
        t_gen();
        end_sim();
    end
endmodule // tlih_top_bench
`default_nettype wire
